// [core/acc_ctrl.v]
// Purpose: Conversion control for a 10-bit successive-approximation converter
// Assumes: AHB-Lite slave, single word transfers, one clock
// Notes: Analog core presents its code on ana_result; it is taken on the edge that raises ana_sample
`timescale 1ns/1ns
`include "acc_defines.vh"
module acc_ctrl #(
	parameter PS_W = 7,
	// Eight 3-bit entries: source index for each select code
	parameter [23:0] TRIG_MAP = 24'hFAC_688
) (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	// Trigger sources; index 0 unused, completion flag used instead
	input wire [7:0] trig_src,
	// Analog core
	input wire [9:0] ana_result,
	output reg ana_sample,
	output reg [1:0] ana_reference,
	output reg [5:0] ana_channel,
	output reg ana_gain_20x,
	output reg ana_gain_bypass,
	output reg ana_temp_sel,
	output reg ana_enable,
	output reg ana_bipolar,
	output reg cmp_neg_from_mux,
	output reg [2:0] cmp_mux_sel,
	output reg [7:0] pin_buf_en,
	// Pin states from port
	input wire [7:0] pin_raw,
	// Completion event
	output wire conv_done_irq
);
	reg [7:0] chref_q;
	reg [7:0] ctrla_q;
	reg [7:0] ctrlb_q;
	reg [7:0] didr_q;
	reg [7:0] resl_q;
	reg [7:0] resh_q;
	reg [7:0] act_chref_q;
	reg busy_q;
	reg first_q;
	reg lock_q;
	reg pend_q;
	reg [4:0] cyc_q;
	reg [PS_W-1:0] ps_q;
	reg trig_q;
	reg done_q;
	reg ph_wr_q;
	reg ph_rd_q;
	reg [2:0] ph_idx_q;
	reg [31:0] rdata_q;

	wire en = ctrla_q[`ACC_A_EN];
	wire auto_en = ctrla_q[`ACC_A_AUTO];
	wire [2:0] tsel = ctrlb_q[2:0];
	wire [2:0] src_idx = TRIG_MAP[tsel*3 +: 3];
	wire free_run = (tsel == `ACC_TS_FREE);
	wire trig_lvl = free_run ? ctrla_q[`ACC_A_FLAG] : trig_src[src_idx];
	// Edge only; a level that stays high cannot restart
	wire trig_edge = auto_en && en && !free_run && trig_lvl && !trig_q;
	wire ps_tick = (ps_q == {PS_W{1'b1}});
	wire [4:0] cyc_len = first_q ? `ACC_CYC_FIRST : `ACC_CYC_NORMAL;
	wire conv_end = busy_q && ps_tick && (cyc_q == cyc_len - 5'd1);
	// Free running restarts at completion regardless of the flag
	wire restart = conv_end && auto_en && free_run;
	wire addr_ok = hsel && hready && htrans[1];
	wire wr_a = ph_wr_q && ph_idx_q == `ACC_IDX_CTRLA;
	wire sw_start = wr_a && hwdata[`ACC_A_START] && en;
	wire start_now = !busy_q && (pend_q || trig_edge) && ps_tick;
	wire [15:0] res_word;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;
	assign conv_done_irq = done_q;
	// Right adjusted by default, left adjusted on request
	assign res_word = ctrlb_q[`ACC_B_LAR] ? {ana_result, 6'h00} : {6'h00, ana_result};

	// Bus address phase capture and read data
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ph_wr_q <= 1'b0;
			ph_rd_q <= 1'b0;
			ph_idx_q <= 3'd0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ph_wr_q <= addr_ok && hwrite;
			ph_rd_q <= addr_ok && !hwrite;
			ph_idx_q <= haddr[4:2];
			if (addr_ok && !hwrite) begin
				case (haddr[4:2])
				`ACC_IDX_CHREF: rdata_q <= {24'h0, chref_q};
				// Start bit reads one whenever busy
				`ACC_IDX_CTRLA: rdata_q <= {24'h0, ctrla_q | {1'b0, busy_q, 6'h00}};
				`ACC_IDX_CTRLB: rdata_q <= {24'h0, ctrlb_q};
				`ACC_IDX_RESL: rdata_q <= {24'h0, resl_q};
				`ACC_IDX_RESH: rdata_q <= {24'h0, resh_q};
				`ACC_IDX_DIDR: rdata_q <= {24'h0, didr_q};
				`ACC_IDX_PINS: rdata_q <= {24'h0, pin_raw & ~didr_q};
				default: rdata_q <= 32'h0000_0000;
				endcase
			end else begin
				rdata_q <= 32'h0000_0000;
			end
		end
	end

	// Register writes, result lock, start and completion
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			chref_q <= `ACC_RST_BYTE;
			ctrla_q <= `ACC_RST_BYTE;
			ctrlb_q <= `ACC_RST_BYTE;
			didr_q <= `ACC_RST_BYTE;
			resl_q <= `ACC_RST_BYTE;
			resh_q <= `ACC_RST_BYTE;
			lock_q <= 1'b0;
			pend_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= conv_end;
			if (ph_wr_q && ph_idx_q == `ACC_IDX_CHREF)
				chref_q <= hwdata[7:0];
			if (ph_wr_q && ph_idx_q == `ACC_IDX_CTRLB)
				ctrlb_q <= hwdata[7:0] & `ACC_MASK_B;
			if (ph_wr_q && ph_idx_q == `ACC_IDX_DIDR)
				didr_q <= hwdata[7:0] & `ACC_MASK_D;
			if (wr_a) begin
				ctrla_q[7] <= hwdata[7];
				ctrla_q[5] <= hwdata[5];
				ctrla_q[3:0] <= hwdata[3:0];
			end
			// Flag: set wins over write-one clear
			if (conv_end)
				ctrla_q[`ACC_A_FLAG] <= 1'b1;
			else if (wr_a && hwdata[`ACC_A_FLAG])
				ctrla_q[`ACC_A_FLAG] <= 1'b0;
			// Start bit is a pure busy view; the stored copy stays zero
			ctrla_q[`ACC_A_START] <= 1'b0;
			if (!en || start_now)
				pend_q <= 1'b0;
			else if (sw_start)
				pend_q <= 1'b1;
			// Trigger edge is one clock wide; hold it until the preset tick
			else if (trig_edge && !busy_q)
				pend_q <= 1'b1;
			if (ph_rd_q && ph_idx_q == `ACC_IDX_RESL)
				lock_q <= 1'b1;
			else if (ph_rd_q && ph_idx_q == `ACC_IDX_RESH)
				lock_q <= 1'b0;
			if (conv_end && !lock_q) begin
				resl_q <= res_word[7:0];
				resh_q <= res_word[15:8];
			end
		end
	end

	// Prescaler, conversion sequencing
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ps_q <= {PS_W{1'b0}};
			busy_q <= 1'b0;
			first_q <= 1'b1;
			cyc_q <= 5'd0;
			trig_q <= 1'b0;
			act_chref_q <= `ACC_RST_BYTE;
			ana_sample <= 1'b0;
		end else begin
			trig_q <= trig_lvl;
			ana_sample <= conv_end;
			if (!en) begin
				ps_q <= {PS_W{1'b0}};
				busy_q <= 1'b0;
				first_q <= 1'b1;
				cyc_q <= 5'd0;
			end else if (trig_edge && !busy_q) begin
				ps_q <= {PS_W{1'b1}};
			end else begin
				ps_q <= ps_q + {{(PS_W-1){1'b0}}, 1'b1};
			end
			// Selection tracks software only while idle, and reloads at a free running restart
			if (en && !busy_q)
				act_chref_q <= chref_q;
			if (en && start_now) begin
				busy_q <= 1'b1;
				cyc_q <= 5'd0;
			end else if (en && conv_end) begin
				first_q <= 1'b0;
				cyc_q <= 5'd0;
				busy_q <= restart;
				if (restart)
					act_chref_q <= chref_q;
			end else if (en && busy_q && ps_tick) begin
				cyc_q <= cyc_q + 5'd1;
			end
		end
	end

	// Analog side steering
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ana_enable <= 1'b0;
			ana_reference <= 2'b00;
			ana_channel <= 6'h00;
			ana_gain_20x <= 1'b0;
			ana_gain_bypass <= 1'b1;
			ana_temp_sel <= 1'b0;
			ana_bipolar <= 1'b0;
			cmp_neg_from_mux <= 1'b0;
			cmp_mux_sel <= 3'd0;
			pin_buf_en <= 8'hFF;
		end else begin
			ana_enable <= en;
			ana_bipolar <= ctrlb_q[`ACC_B_BIN];
			if (en) begin
				ana_reference <= act_chref_q[7:6];
				ana_channel <= act_chref_q[5:0];
				// Codes below 8 are single ended and bypass gain
				ana_gain_bypass <= (act_chref_q[5:3] == 3'd0);
				ana_gain_20x <= (act_chref_q[5:3] != 3'd0) && act_chref_q[0];
				ana_temp_sel <= (act_chref_q[5:0] == `ACC_CH_TEMP);
			end
			cmp_neg_from_mux <= ctrlb_q[`ACC_B_CME] && !en;
			cmp_mux_sel <= chref_q[2:0];
			pin_buf_en <= {5'h1F, ~didr_q[`ACC_D_PIN2], ~didr_q[`ACC_D_PIN1], 1'b1};
		end
	end
endmodule

// [core/acc_defines.vh]
// Purpose: Constants for the converter control block
// Assumes: AHB-Lite word-indexed register map
// Notes: Byte address is four times the register index
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH
// Register indices
`define ACC_IDX_CHREF 3'd0
`define ACC_IDX_CTRLA 3'd1
`define ACC_IDX_CTRLB 3'd3
`define ACC_IDX_RESL 3'd4
`define ACC_IDX_RESH 3'd5
`define ACC_IDX_DIDR 3'd6
`define ACC_IDX_PINS 3'd7
// Control A fields
`define ACC_A_EN 7
`define ACC_A_START 6
`define ACC_A_AUTO 5
`define ACC_A_FLAG 4
// Control B fields
`define ACC_B_BIN 7
`define ACC_B_CME 6
`define ACC_B_LAR 4
// Digital input disable fields
`define ACC_D_PIN1 1
`define ACC_D_PIN2 2
// Reset values and masks
`define ACC_RST_BYTE 8'h00
`define ACC_MASK_B 8'hD7
`define ACC_MASK_D 8'h06
// Channel code of the temperature sensor
`define ACC_CH_TEMP 6'h22
// Trigger select code treated as free running
`define ACC_TS_FREE 3'h0
// Conversion lengths in converter clock cycles
`define ACC_CYC_NORMAL 5'd13
`define ACC_CYC_FIRST 5'd25
`endif

// [verif/acc_ana_model.sv]
// Purpose: Analog core stand-in for the converter control block
// Assumes: Code is taken by the block while the channel is still locked
// Notes: Code carries the channel so a stale channel shows in the result
`timescale 1ns/1ns
module acc_ana_model (
	// From block
	input wire [5:0] ana_channel,
	// To block
	output wire [9:0] ana_result
);
	assign ana_result = {4'hA, ana_channel};
endmodule

// [verif/acc_ctrl_assertions.sv]
// Purpose: Port checker for the converter control block
// Assumes: Single clock, reset low active
// Notes: Bound to every instance of the block
`timescale 1ns/1ns
module acc_chk (
	// Bus
	input wire clk,
	input wire rstn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	// Converter
	input wire ana_sample,
	input wire ana_enable,
	input wire [5:0] ana_channel,
	input wire ana_temp_sel,
	input wire cmp_neg_from_mux,
	input wire [7:0] pin_buf_en,
	input wire conv_done_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_okay; hreadyout && !hresp; endproperty
	a_okay: assert property (p_okay) else $error("bus stalled or errored");
	property p_rdz; !(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0000_0000; endproperty
	a_rdz: assert property (p_rdz) else $error("read data outside a read");
	property p_cmp; cmp_neg_from_mux |-> !ana_enable; endproperty
	a_cmp: assert property (p_cmp) else $error("comparator mux while enabled");
	property p_buf; pin_buf_en[0] && pin_buf_en[7:3] == 5'h1F; endproperty
	a_buf: assert property (p_buf) else $error("unrelated input buffer off");
	property p_temp; ana_temp_sel |-> ana_channel == 6'h22; endproperty
	a_temp: assert property (p_temp) else $error("sensor on wrong code");
	property p_pair; conv_done_irq |-> ana_sample; endproperty
	a_pair: assert property (p_pair) else $error("done without sample");
	property p_gap; conv_done_irq |=> !conv_done_irq [*8]; endproperty
	a_gap: assert property (p_gap) else $error("conversions too close");
	property p_en; $rose(ana_enable) |-> !conv_done_irq [*8]; endproperty
	a_en: assert property (p_en) else $error("done right after enable");
endmodule
bind acc_ctrl acc_chk u_chk (.*);

// [verif/tb_adc_conversion_control.sv]
// Purpose: Register level bench for the converter control block
// Assumes: Prescaler shortened to four clocks a tick
// Notes: Conversion lengths checked within a small slack window
`timescale 1ns/1ns
`include "acc_defines.vh"
module tb_adc_conversion_control;
	reg clk = 0, rstn = 0, hsel = 1, hwrite = 0;
	reg [31:0] haddr = 0, hwdata = 0;
	reg [1:0] htrans = 0;
	reg [7:0] trig_src = 0;
	wire [31:0] hrdata;
	wire [9:0] ana_result;
	wire [5:0] ana_channel;
	wire [7:0] pin_buf_en;
	wire hreadyout, cmp_neg_from_mux, conv_done_irq;
	reg [31:0] r;
	int num_errors = 0, checks_done = 0, k, n0, nirq = 0;
	always #2 clk = ~clk;
	always @(posedge clk) if (conv_done_irq === 1'b1) nirq <= nirq + 1;
	acc_ctrl #(.PS_W(2)) dut_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .trig_src(trig_src),
		.ana_result(ana_result), .ana_sample(), .ana_reference(), .ana_channel(ana_channel),
		.ana_gain_20x(), .ana_gain_bypass(), .ana_temp_sel(), .ana_enable(), .ana_bipolar(),
		.cmp_neg_from_mux(cmp_neg_from_mux), .cmp_mux_sel(), .pin_buf_en(pin_buf_en),
		.pin_raw(8'hFF), .conv_done_irq(conv_done_irq));
	acc_ana_model u_ana (.ana_channel(ana_channel), .ana_result(ana_result));
	task close_out;
		if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input [31:0] s, input [31:0] e, input string n);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	// Waits on ready or on completion; a hang ends the run
	task wt(input bit irq, output int c);
		c = 0;
		@(posedge clk);
		while ((irq ? conv_done_irq : hreadyout) !== 1'b1 && c < 400) begin
			c++;
			@(posedge clk);
		end
		if (c >= 400) begin
			num_errors++;
			close_out;
		end
	endtask
	task bus(input [2:0] i, input bit w, input [7:0] d);
		int c;
		haddr <= {27'h0, i, 2'b00};
		hwrite <= w;
		htrans <= 2'b10;
		wt(0, c);
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		wt(0, c);
		r = hrdata;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1;
		bus(`ACC_IDX_CTRLB, 0, 0); chk(r, 0, "ctrlb_rst");
		bus(`ACC_IDX_CTRLB, 1, 8'hFF); bus(`ACC_IDX_CTRLB, 0, 0); chk(r, 32'hD7, "ctrlb");
		bus(3'd2, 0, 0); chk(r, 0, "unmapped");
		bus(`ACC_IDX_DIDR, 1, 8'h06); bus(`ACC_IDX_PINS, 0, 0); chk(r, 32'hF9, "pins");
		chk(pin_buf_en, 8'hF9, "buf_en");
		bus(`ACC_IDX_CTRLB, 1, 8'h40); bus(`ACC_IDX_CHREF, 1, 8'h05);
		chk(cmp_neg_from_mux, 1, "cmp_mux");
		bus(`ACC_IDX_CTRLA, 1, 8'h80);
		bus(`ACC_IDX_CTRLA, 1, 8'hC0); wt(1, k); chk(k >= 100 && k <= 108, 1, "first_len");
		chk(cmp_neg_from_mux, 0, "cmp_pin");
		bus(`ACC_IDX_CTRLA, 0, 0); chk(r, 32'h90, "ctrla_done");
		bus(`ACC_IDX_RESL, 0, 0); chk(r, 32'h85, "low_r");
		bus(`ACC_IDX_RESH, 0, 0); chk(r, 32'h02, "high_r");
		bus(`ACC_IDX_CTRLB, 1, 8'h10); bus(`ACC_IDX_CTRLA, 1, 8'hD0);
		wt(1, k); chk(k >= 52 && k <= 60, 1, "norm_len");
		bus(`ACC_IDX_RESL, 0, 0); chk(r, 32'h40, "low_l");
		bus(`ACC_IDX_CHREF, 1, 8'h06); bus(`ACC_IDX_CTRLA, 1, 8'hD0); wt(1, k);
		bus(`ACC_IDX_CTRLA, 0, 0); chk(r, 32'h90, "flag_lost");
		bus(`ACC_IDX_RESH, 0, 0); chk(r, 32'hA1, "high_lock");
		bus(`ACC_IDX_RESL, 0, 0); chk(r, 32'h40, "low_lost");
		bus(`ACC_IDX_RESH, 0, 0);
		bus(`ACC_IDX_CTRLA, 1, 8'hD0); repeat (8) @(posedge clk);
		bus(`ACC_IDX_CHREF, 1, 8'h07); wt(1, k);
		bus(`ACC_IDX_RESL, 0, 0); chk(r, 32'h80, "low_unlock");
		bus(`ACC_IDX_RESH, 0, 0);
		bus(`ACC_IDX_CTRLA, 1, 8'hE0); wt(1, k); wt(1, k); chk(k <= 60, 1, "free_run");
		bus(`ACC_IDX_CTRLA, 0, 0); chk(r & 32'h40, 32'h40, "busy_auto");
		bus(`ACC_IDX_CTRLB, 1, 8'h11); bus(`ACC_IDX_CTRLA, 1, 8'hB0); wt(1, k);
		repeat (80) @(posedge clk);
		n0 = nirq;
		trig_src <= 8'h02; wt(1, k); chk(k <= 58, 1, "trig_start");
		repeat (120) @(posedge clk);
		chk(nirq - n0, 1, "held_trig");
		trig_src <= 8'h00; @(posedge clk); trig_src <= 8'h02; wt(1, k);
		@(posedge clk);
		chk(nirq - n0, 2, "second_edge");
		close_out;
	end
endmodule
